// ### hdl/hold_counter.sv
/*
  tick counter that reports when a condition has held for a set time.
  assumes tick is a one-cycle enable on the same clock as the condition.
*/
`timescale 1ns/1ps
module hold_counter #(
  parameter int W = 10
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         tick,
  input  wire logic         cond,
  input  wire logic [W-1:0] limit,
  output logic              done
);
  typedef struct packed {
    logic [W-1:0] cnt;   // elapsed ticks
    logic         done;  // condition held long enough
  } hc_t;

  hc_t st_r;
  hc_t st_nxt;

  // count ticks while the condition holds, restart when it drops
  always_comb begin
    st_nxt = st_r;
    if (!cond) begin
      st_nxt.cnt = '0;
    end else if (tick && st_r.cnt < limit) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
    st_nxt.done = cond && (st_nxt.cnt >= limit);
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done = st_r.done;
endmodule

// ### hdl/prot_pkg.sv
/*
  constants, types and register map of the inverter protection block.
  assumes a single 10 MHz control clock and a simple strobe register port.
*/
package prot_pkg;
  // clock and protection tick
  localparam int CLK_HZ      = 10_000_000;     // control clock rate
  localparam int TICK_MS     = 100;            // protection tick, 0.1 s
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TICK_W      = 20;             // holds TICK_CYCLES - 1

  // widths
  localparam int N_TERM = 7;                   // multi-function inputs
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TIME_W = 10;                  // times in 0.1 s units
  localparam int PCT_W  = 7;                   // percent of rated current
  localparam int VAL_W  = 16;                  // frequency / current words
  localparam int FN_W   = 8;                   // function code width
  localparam int N_EV   = 5;                   // interrupt events

  // input terminal function codes
  localparam logic [FN_W-1:0] FN_RESET = 8'h03;
  localparam logic [FN_W-1:0] FN_BLOCK = 8'h05;
  // output function code: low voltage indication
  localparam logic [FN_W-1:0] OUT_FN_LOWVOLT = 8'h0b;

  // option card fault reaction
  typedef enum logic [1:0] {
    OPT_NONE,
    OPT_FREE_RUN,
    OPT_DECEL,
    OPT_SPARE
  } opt_mode_t;

  // output block sequence
  typedef enum logic [1:0] {
    BLK_CLEAR,
    BLK_ACTIVE,
    BLK_WAIT_RUN
  } blk_state_t;

  // reset values
  localparam logic [TIME_W-1:0] UV_DELAY_RST = 10'h000;  // 0.0 s
  localparam logic [PCT_W-1:0]  NM_LEVEL_RST = 7'h05;    // 5 %
  localparam logic [TIME_W-1:0] NM_TIME_RST  = 10'h01e;  // 3.0 s

  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] REG_UV_DELAY  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_NM_LEVEL  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_NM_TIME   = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_TERM_BASE = 8'h10;   // 7 words
  localparam logic [ADDR_W-1:0] REG_OUT_FN    = 8'h2c;
  localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h30;
  localparam logic [ADDR_W-1:0] REG_HELD_FREQ = 8'h34;
  localparam logic [ADDR_W-1:0] REG_HELD_CUR  = 8'h38;
  localparam logic [ADDR_W-1:0] REG_DIAG      = 8'h3c;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT  = 8'h40;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLR   = 8'h44;
  localparam logic [ADDR_W-1:0] REG_IRQ_EN    = 8'h48;

  // control register fields
  localparam int CTRL_LV2_BIT = 0;
  localparam int CTRL_NM_BIT  = 1;
  localparam int CTRL_OPT_LSB = 2;

  // interrupt event bits
  localparam int EV_UV    = 0;
  localparam int EV_BLOCK = 1;
  localparam int EV_OPT   = 2;
  localparam int EV_NM    = 3;
  localparam int EV_DIAG  = 4;

  // trip history codes
  localparam logic [3:0] TRIP_UV  = 4'h1;
  localparam logic [3:0] TRIP_OPT = 4'h2;
  localparam logic [3:0] TRIP_NM  = 4'h3;
endpackage

// ### hdl/prot_trip.sv
/*
  protection and trip handling of a motor inverter: undervoltage trip,
  output block and trip reset terminals, option card fault reaction,
  no-motor detection, diagnosis word, register port and interrupt.
  assumes pins are asynchronous, measurement words are on clk.
*/
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
module prot_trip #(
  parameter int TICK_CYCLES = prot_pkg::TICK_CYCLES
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic [prot_pkg::ADDR_W-1:0]   addr,
  input  wire logic [prot_pkg::DATA_W-1:0]   wdata,
  input  wire logic                          wr_en,
  input  wire logic                          rd_en,
  output logic      [prot_pkg::DATA_W-1:0]   rdata,
  input  wire logic                          dc_undervolt,
  input  wire logic [prot_pkg::N_TERM-1:0]   terminal_in,
  input  wire logic                          stop_reset_key,
  input  wire logic                          run_cmd,
  input  wire logic                          opt_comm_fail,
  input  wire logic                          opt_card_absent,
  input  wire logic [prot_pkg::VAL_W-1:0]    out_freq,
  input  wire logic [prot_pkg::VAL_W-1:0]    out_current,
  input  wire logic [prot_pkg::PCT_W-1:0]    current_pct,
  input  wire logic                          capacitor_replace_flag,
  input  wire logic                          fan_replace_flag,
  output logic                               drive_enable,
  output logic                               decel_request,
  output logic                               block_display,
  output logic                               relay1_out,
  output logic                               relay2_out,
  output logic                               open_collector_out,
  output logic                               trip_log_wr,
  output logic      [3:0]                    trip_log_code,
  output logic                               irq
);
  localparam int NT = prot_pkg::N_TERM;
  localparam int FW = prot_pkg::FN_W;
  localparam int ADDR_IDX_W = 3;   // terminal index width, seven slots

  typedef struct packed {
    logic [NT+4:0]          sync1;      // first sync stage, pins
    logic [NT+4:0]          sync2;      // second sync stage
    logic [prot_pkg::TICK_W-1:0] tick_cnt;
    logic                   tick;       // 0.1 s enable
    logic                   ctrl_lv2;   // latched undervoltage select
    logic                   ctrl_nm_en; // no-motor action enable
    prot_pkg::opt_mode_t    opt_mode;   // option fault reaction
    logic [prot_pkg::TIME_W-1:0] uv_delay;
    logic [prot_pkg::PCT_W-1:0]  nm_level;
    logic [prot_pkg::TIME_W-1:0] nm_time;
    logic [NT-1:0][FW-1:0]  term_fn;    // input terminal function
    logic [2:0][FW-1:0]     out_fn;     // relay1, relay2, open collector
    logic                   lv2;        // latched undervoltage trip
    logic                   opt_trip;   // option card trip
    logic                   nm_trip;    // no-motor trip
    logic                   decel;      // deceleration stop request
    prot_pkg::blk_state_t   blk;        // output block sequence
    logic [prot_pkg::VAL_W-1:0] held_freq;
    logic [prot_pkg::VAL_W-1:0] held_cur;
    logic                   run_q;      // run for edge detect
    logic                   rst_q;      // reset request for edge detect
    logic                   uv_q;       // undervoltage for edge detect
    logic                   cap_q;      // capacitor flag for edge detect
    logic                   drive;
    logic [2:0]             outs;       // output terminal levels
    logic                   log_wr;
    logic [3:0]             log_code;
    logic [prot_pkg::N_EV-1:0] irq_stat;
    logic [prot_pkg::N_EV-1:0] irq_en;
    logic                   irq;
    logic [prot_pkg::DATA_W-1:0] rdata;
  } st_t;

  st_t  st_r;
  st_t  st_nxt;
  logic uv_ind_done;   // undervoltage held past indicate delay
  logic nm_done;       // low current held past detect time

  // true when any terminal with the given function is asserted
  function automatic logic term_active(input logic [NT-1:0][FW-1:0] fn,
                                       input logic [NT-1:0] lvl,
                                       input logic [FW-1:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NT; i++) begin
      if (fn[i] == code && lvl[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // level of one output terminal for its assigned function
  function automatic logic out_level(input logic [FW-1:0] code,
                                     input logic uv_ind);
    return (code == prot_pkg::OUT_FN_LOWVOLT) && uv_ind;
  endfunction

  // synchronised pin levels
  logic [NT-1:0] term_s;
  logic          uv_s;
  logic          key_s;
  logic          run_s;
  logic          comm_s;
  logic          absent_s;
  assign term_s   = st_r.sync2[NT-1:0];
  assign uv_s     = st_r.sync2[NT];
  assign key_s    = st_r.sync2[NT+1];
  assign run_s    = st_r.sync2[NT+2];
  assign comm_s   = st_r.sync2[NT+3];
  assign absent_s = st_r.sync2[NT+4];

  // derived conditions
  logic uv_active;
  logic rst_req;
  logic trip_reset;
  logic block_in;
  logic running;
  logic opt_fault;
  logic run_rise;
  assign uv_active  = uv_s | st_r.lv2;
  assign rst_req    = term_active(st_r.term_fn, term_s,
                                  prot_pkg::FN_RESET) | key_s;
  assign trip_reset = rst_req & ~st_r.rst_q;
  assign block_in   = term_active(st_r.term_fn, term_s,
                                  prot_pkg::FN_BLOCK);
  assign running    = run_s & st_r.drive;
  assign opt_fault  = comm_s | (absent_s & running);
  assign run_rise   = run_s & ~st_r.run_q;

  // undervoltage indicate delay
  hold_counter #(.W(prot_pkg::TIME_W)) u_uv_delay (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (st_r.tick),
    .cond  (uv_active),
    .limit (st_r.uv_delay),
    .done  (uv_ind_done)
  );

  // no-motor detection time, only while running and enabled
  hold_counter #(.W(prot_pkg::TIME_W)) u_nm_time (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (st_r.tick),
    .cond  (st_r.ctrl_nm_en && running &&
            current_pct < st_r.nm_level),
    .limit (st_r.nm_time),
    .done  (nm_done)
  );

  // all next-state logic
  always_comb begin
    logic [prot_pkg::N_EV-1:0] ev;
    logic [ADDR_IDX_W-1:0]     idx;
    st_nxt = st_r;
    ev     = '0;
    idx    = '0;
    // pin synchronisers
    st_nxt.sync1 = {opt_card_absent, opt_comm_fail, run_cmd,
                    stop_reset_key, dc_undervolt, terminal_in};
    st_nxt.sync2 = st_r.sync1;
    // protection tick divider
    if (st_r.tick_cnt == TICK_CYCLES[prot_pkg::TICK_W-1:0] - 1'b1) begin
      st_nxt.tick_cnt = '0;
      st_nxt.tick     = 1'b1;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 1'b1;
      st_nxt.tick     = 1'b0;
    end
    st_nxt.run_q  = run_s;
    st_nxt.rst_q  = rst_req;
    st_nxt.uv_q   = uv_s;
    st_nxt.cap_q  = capacitor_replace_flag;
    st_nxt.log_wr = 1'b0;
    // latched undervoltage: cleared by reset only, set wins
    if (trip_reset) begin
      st_nxt.lv2 = 1'b0;
    end
    if (uv_s && st_r.ctrl_lv2) begin
      st_nxt.lv2 = 1'b1;
    end
    // trip reset clears option and no-motor trips
    if (trip_reset) begin
      st_nxt.opt_trip = 1'b0;
      st_nxt.nm_trip  = 1'b0;
      st_nxt.decel    = 1'b0;
    end
    // option card fault reaction
    if (opt_fault) begin
      case (st_r.opt_mode)
        prot_pkg::OPT_FREE_RUN: st_nxt.opt_trip = 1'b1;
        prot_pkg::OPT_DECEL:    st_nxt.decel    = 1'b1;
        default:                ;
      endcase
      ev[prot_pkg::EV_OPT] = 1'b1;
    end
    // no-motor trip
    if (nm_done) begin
      st_nxt.nm_trip = 1'b1;
    end
    // output block sequence
    case (st_r.blk)
      prot_pkg::BLK_CLEAR: begin
        if (block_in && running) begin
          st_nxt.blk       = prot_pkg::BLK_ACTIVE;
          st_nxt.held_freq = out_freq;
          st_nxt.held_cur  = out_current;
          ev[prot_pkg::EV_BLOCK] = 1'b1;
        end
      end
      prot_pkg::BLK_ACTIVE: begin
        if (!block_in) begin
          st_nxt.blk = prot_pkg::BLK_WAIT_RUN;
        end
      end
      prot_pkg::BLK_WAIT_RUN: begin
        if (block_in) begin
          st_nxt.blk = prot_pkg::BLK_ACTIVE;
        end else if (run_rise) begin
          st_nxt.blk = prot_pkg::BLK_CLEAR;
        end
      end
      default: st_nxt.blk = prot_pkg::BLK_CLEAR;
    endcase
    // drive enable: any trip or block stops output at once
    st_nxt.drive = run_s && !uv_active && !st_nxt.opt_trip &&
                   !st_nxt.nm_trip &&
                   st_nxt.blk == prot_pkg::BLK_CLEAR;
    // output terminals
    for (int k = 0; k < 3; k++) begin
      st_nxt.outs[k] = out_level(st_r.out_fn[k], uv_ind_done);
    end
    // trip history, latched undervoltage is not recorded
    if (uv_s && !st_r.uv_q) begin
      ev[prot_pkg::EV_UV] = 1'b1;
      if (!st_r.ctrl_lv2) begin
        st_nxt.log_wr   = 1'b1;
        st_nxt.log_code = prot_pkg::TRIP_UV;
      end
    end else if (st_nxt.opt_trip && !st_r.opt_trip) begin
      st_nxt.log_wr   = 1'b1;
      st_nxt.log_code = prot_pkg::TRIP_OPT;
    end else if (st_nxt.nm_trip && !st_r.nm_trip) begin
      st_nxt.log_wr   = 1'b1;
      st_nxt.log_code = prot_pkg::TRIP_NM;
    end
    if (st_nxt.nm_trip && !st_r.nm_trip) begin
      ev[prot_pkg::EV_NM] = 1'b1;
    end
    if (capacitor_replace_flag && !st_r.cap_q) begin
      ev[prot_pkg::EV_DIAG] = 1'b1;
    end
    // register writes
    if (wr_en) begin
      case (addr)
        prot_pkg::REG_CTRL: begin
          st_nxt.ctrl_lv2   = wdata[prot_pkg::CTRL_LV2_BIT];
          st_nxt.ctrl_nm_en = wdata[prot_pkg::CTRL_NM_BIT];
          st_nxt.opt_mode   = prot_pkg::opt_mode_t'(
                              wdata[prot_pkg::CTRL_OPT_LSB +: 2]);
        end
        prot_pkg::REG_UV_DELAY: st_nxt.uv_delay = wdata[prot_pkg::TIME_W-1:0];
        prot_pkg::REG_NM_LEVEL: st_nxt.nm_level = wdata[prot_pkg::PCT_W-1:0];
        prot_pkg::REG_NM_TIME:  st_nxt.nm_time  = wdata[prot_pkg::TIME_W-1:0];
        prot_pkg::REG_OUT_FN:   st_nxt.out_fn   = wdata[3*FW-1:0];
        prot_pkg::REG_IRQ_CLR:  st_nxt.irq_stat =
                                st_r.irq_stat & ~wdata[prot_pkg::N_EV-1:0];
        prot_pkg::REG_IRQ_EN:   st_nxt.irq_en   = wdata[prot_pkg::N_EV-1:0];
        default: begin
          if (term_hit(addr)) begin
            idx = term_idx(addr);
            st_nxt.term_fn[idx] = wdata[FW-1:0];
          end
        end
      endcase
    end
    // events set after the clear so a coincident event wins
    st_nxt.irq_stat = st_nxt.irq_stat | ev;
    st_nxt.irq      = |(st_nxt.irq_stat & st_nxt.irq_en);
    // register reads, data valid the cycle after the strobe
    st_nxt.rdata = '0;
    if (rd_en) begin
      case (addr)
        prot_pkg::REG_CTRL: begin
          st_nxt.rdata[prot_pkg::CTRL_LV2_BIT] = st_r.ctrl_lv2;
          st_nxt.rdata[prot_pkg::CTRL_NM_BIT]  = st_r.ctrl_nm_en;
          st_nxt.rdata[prot_pkg::CTRL_OPT_LSB +: 2] = st_r.opt_mode;
        end
        prot_pkg::REG_UV_DELAY:  st_nxt.rdata[prot_pkg::TIME_W-1:0] = st_r.uv_delay;
        prot_pkg::REG_NM_LEVEL:  st_nxt.rdata[prot_pkg::PCT_W-1:0] = st_r.nm_level;
        prot_pkg::REG_NM_TIME:   st_nxt.rdata[prot_pkg::TIME_W-1:0] = st_r.nm_time;
        prot_pkg::REG_OUT_FN:    st_nxt.rdata[3*FW-1:0] = st_r.out_fn;
        prot_pkg::REG_STATUS:    st_nxt.rdata[7:0] =
          {st_r.decel, st_r.blk != prot_pkg::BLK_CLEAR, st_r.nm_trip,
           st_r.opt_trip, st_r.lv2, uv_s, st_r.drive, uv_ind_done};
        prot_pkg::REG_HELD_FREQ: st_nxt.rdata[prot_pkg::VAL_W-1:0] = st_r.held_freq;
        prot_pkg::REG_HELD_CUR:  st_nxt.rdata[prot_pkg::VAL_W-1:0] = st_r.held_cur;
        prot_pkg::REG_DIAG:      st_nxt.rdata[1:0] =
          {fan_replace_flag, capacitor_replace_flag};
        prot_pkg::REG_IRQ_STAT:  st_nxt.rdata[prot_pkg::N_EV-1:0] = st_r.irq_stat;
        prot_pkg::REG_IRQ_EN:    st_nxt.rdata[prot_pkg::N_EV-1:0] = st_r.irq_en;
        default: begin
          if (term_hit(addr)) begin
            idx = term_idx(addr);
            st_nxt.rdata[FW-1:0] = st_r.term_fn[idx];
          end
        end
      endcase
    end
  end

  // terminal function word decode
  function automatic logic term_hit(input logic [prot_pkg::ADDR_W-1:0] a);
    logic [prot_pkg::ADDR_W-1:0] off;
    off = a - prot_pkg::REG_TERM_BASE;
    return (a >= prot_pkg::REG_TERM_BASE) && (off[1:0] == 2'b00) &&
           (off[prot_pkg::ADDR_W-1:2] < NT[prot_pkg::ADDR_W-3:0]);
  endfunction
  function automatic logic [ADDR_IDX_W-1:0] term_idx(
      input logic [prot_pkg::ADDR_W-1:0] a);
    logic [prot_pkg::ADDR_W-1:0] off;
    off = a - prot_pkg::REG_TERM_BASE;
    return off[ADDR_IDX_W+1:2];
  endfunction

  // state register with documented reset values
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r          <= '0;
      st_r.uv_delay <= prot_pkg::UV_DELAY_RST;
      st_r.nm_level <= prot_pkg::NM_LEVEL_RST;
      st_r.nm_time  <= prot_pkg::NM_TIME_RST;
      st_r.opt_mode <= prot_pkg::OPT_NONE;
      st_r.blk      <= prot_pkg::BLK_CLEAR;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign rdata              = st_r.rdata;
  assign drive_enable       = st_r.drive;
  assign decel_request      = st_r.decel;
  assign block_display      = (st_r.blk != prot_pkg::BLK_CLEAR) ? 1'b1 : 1'b0;
  assign relay1_out         = st_r.outs[0];
  assign relay2_out         = st_r.outs[1];
  assign open_collector_out = st_r.outs[2];
  assign trip_log_wr        = st_r.log_wr;
  assign trip_log_code      = st_r.log_code;
  assign irq                = st_r.irq;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_uv_stop_drive: assert property (uv_s |=> !st_r.drive)
    else $error("drive not stopped on undervoltage");
  a_block_drive_off: assert property (
    st_r.blk != prot_pkg::BLK_CLEAR |-> !st_r.drive)
    else $error("drive on while blocked");
  a_block_hold_vals: assert property (
    st_r.blk != prot_pkg::BLK_CLEAR ##1 st_r.blk != prot_pkg::BLK_CLEAR
    |-> $stable(st_r.held_freq) && $stable(st_r.held_cur))
    else $error("held values changed during block");
  a_block_release: assert property (
    st_r.blk == prot_pkg::BLK_WAIT_RUN && !block_in && run_rise
    |=> st_r.blk == prot_pkg::BLK_CLEAR)
    else $error("block not released on new run");
  a_reset_clears: assert property (
    trip_reset && !opt_fault && !nm_done |=> !st_r.opt_trip && !st_r.nm_trip)
    else $error("trip reset did not clear trips");
  a_opt_free_run: assert property (
    opt_fault && st_r.opt_mode == prot_pkg::OPT_FREE_RUN
    |=> st_r.opt_trip && !st_r.drive)
    else $error("option free-run did not trip");
  a_opt_decel: assert property (
    opt_fault && st_r.opt_mode == prot_pkg::OPT_DECEL
    |=> st_r.decel)
    else $error("option decel not requested");
  a_lv2_holds: assert property (
    st_r.lv2 && !trip_reset |=> st_r.lv2)
    else $error("latched undervoltage lost");
  a_lv2_not_logged: assert property (
    $rose(uv_s) && st_r.ctrl_lv2 |=> !st_r.log_wr)
    else $error("latched undervoltage logged");
  a_nm_needs_enable: assert property (
    $rose(st_r.nm_trip) |-> $past(st_r.ctrl_nm_en))
    else $error("no-motor trip while disabled");
  a_irq_level: assert property (
    st_r.irq == |(st_r.irq_stat & st_r.irq_en))
    else $error("irq not matching enabled status");

  c_block_entered: cover property (st_r.blk == prot_pkg::BLK_ACTIVE);
  c_lv2_latched: cover property (st_r.lv2 && !uv_s);
  c_nm_trip: cover property ($rose(st_r.nm_trip));
  c_decel: cover property ($rose(st_r.decel));
endmodule

// ### verif/motor_model.sv
/*
  stand-in for the power stage and motor: returns measurement words.
  assumes drive_enable comes from the protection block on the same clock.
*/
`timescale 1ns/1ps
module motor_model (
  input  wire logic                       clk,
  input  wire logic                       drive_enable,
  input  wire logic                       motor_on,
  output logic [prot_pkg::VAL_W-1:0]      out_freq = '0,
  output logic [prot_pkg::VAL_W-1:0]      out_current = '0,
  output logic [prot_pkg::PCT_W-1:0]      current_pct = '0
);
  // words follow drive one cycle late; no drive reads zero, no motor zeroes current words only
  always @(posedge clk) begin
    out_freq    <= drive_enable ? 16'h1234 : 16'h0000;
    out_current <= (drive_enable && motor_on) ? 16'h0056 : 16'h0000;
    current_pct <= (drive_enable && motor_on) ? 7'h28 : 7'h00;
  end
endmodule

// ### verif/prot_trip_tb.sv
/*
  self-checking bench of the protection block with the motor stand-in.
  assumes a short tick of 10 clocks; one task per scenario.
*/
`timescale 1ns/1ps
module prot_trip_tb;
  logic clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, dc = 0, key = 0;
  logic run = 0, ofail = 0, oabs = 0, cap = 0, fan = 0, mot = 1;
  logic [7:0] addr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [6:0] term = '0, pct;
  logic [15:0] fq, cu;
  wire [7:0] pins;
  wire [3:0] lc;
  int miscompares = 0, checks_done = 0;
  int logs = 0;
  always #50 clk = ~clk;
  motor_model mm (.clk(clk), .drive_enable(pins[0]), .motor_on(mot),
    .out_freq(fq), .out_current(cu), .current_pct(pct));
  // count trip history pulses mid-cycle, away from the launching edge
  always @(negedge clk) if (pins[5]) logs++;
  prot_trip #(.TICK_CYCLES(10)) uut (.clk(clk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .dc_undervolt(dc), .terminal_in(term),
    .stop_reset_key(key), .run_cmd(run), .opt_comm_fail(ofail),
    .opt_card_absent(oabs), .out_freq(fq), .out_current(cu),
    .current_pct(pct), .capacitor_replace_flag(cap),
    .fan_replace_flag(fan), .drive_enable(pins[0]),
    .decel_request(pins[3]), .block_display(pins[2]),
    .relay1_out(pins[1]), .relay2_out(pins[7]),
    .open_collector_out(pins[6]), .trip_log_wr(pins[5]),
    .trip_log_code(lc), .irq(pins[4]));
  // verdict and end of run
  task automatic tally_and_finish;
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk) begin wr_en <= 1; addr <= a; wdata <= v; end
    @(posedge clk) wr_en <= 0;
  endtask
  // read, data sampled in the cycle after the strobe, then compared
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk) begin rd_en <= 1; addr <= a; end
    @(posedge clk) rd_en <= 0;
    #1 chk(rdata, exp);
  endtask
  // bounded wait for an output pin level
  task automatic waitp(input int i, input logic v, input int n);
    while (pins[i] !== v && n > 0) begin @(posedge clk); #1 n--; end
    chk(pins[i], v);
    if (pins[i] !== v) tally_and_finish();
  endtask
  // pulse the keypad stop-reset key
  task automatic press;
    @(posedge clk) key <= 1;
    repeat (4) @(posedge clk);
    key <= 0;
  endtask
  task automatic s_defaults;
    rd(8'h08, 32'h5);
    rd(8'h0c, 32'h1e);
    rd(8'h00, 32'h0);
    rd(8'h4c, 32'h0);
    cap <= 1; rd(8'h3c, 32'h1);
    fan <= 1; rd(8'h3c, 32'h3);
  endtask
  task automatic s_undervolt;
    wr(8'h04, 32'h2); wr(8'h2c, 32'h0b000b);
    @(posedge clk) dc <= 1;
    waitp(5, 1, 6);
    chk(lc, 32'h1);
    waitp(0, 0, 6);
    repeat (8) @(posedge clk);
    #1 chk(pins[1], 0);
    waitp(1, 1, 40);
    chk(pins[6], 1);
    chk(pins[7], 0);
    @(posedge clk) dc <= 0;
    waitp(0, 1, 10);
  endtask
  task automatic s_block;
    wr(8'h14, 32'h05); wr(8'h48, 32'h2);
    @(posedge clk) term <= 7'h02;
    waitp(0, 0, 6);
    waitp(2, 1, 4);
    waitp(4, 1, 4);
    repeat (4) @(posedge clk);
    rd(8'h34, 32'h1234);
    rd(8'h38, 32'h0056);
    wr(8'h44, 32'h2); waitp(4, 0, 4);
    @(posedge clk) term <= 0;
    repeat (10) @(posedge clk);
    #1 chk(pins[0], 0);
    @(posedge clk) run <= 0;
    repeat (4) @(posedge clk);
    run <= 1;
    waitp(0, 1, 10);
  endtask
  task automatic s_latched;
    wr(8'h00, 32'h1); wr(8'h18, 32'h03);
    @(posedge clk) dc <= 1;
    waitp(0, 0, 6);
    @(posedge clk) dc <= 0;
    repeat (20) @(posedge clk);
    #1 chk(pins[0], 0);
    chk(logs, 32'h1);
    @(posedge clk) term <= 7'h04;
    repeat (4) @(posedge clk);
    term <= 0;
    waitp(0, 1, 10);
    wr(8'h00, 32'h0);
  endtask
  task automatic s_option;
    wr(8'h00, 32'h0); @(posedge clk) ofail <= 1;
    repeat (20) @(posedge clk);
    #1 chk(pins[0], 1);
    wr(8'h00, 32'hc); repeat (6) @(posedge clk);
    #1 chk(pins[0], 1);
    wr(8'h00, 32'h4);
    waitp(0, 0, 10);
    @(posedge clk) ofail <= 0; press(); waitp(0, 1, 10);
    wr(8'h00, 32'h8); @(posedge clk) oabs <= 1;
    waitp(3, 1, 10);
    chk(pins[0], 1);
    @(posedge clk) oabs <= 0; press(); waitp(3, 0, 10);
  endtask
  task automatic s_nomotor;
    wr(8'h08, 32'h3);
    wr(8'h0c, 32'h2); wr(8'h00, 32'h2);
    @(posedge clk) mot <= 0;
    repeat (8) @(posedge clk);
    rd(8'h30, 32'h2);
    repeat (40) @(posedge clk);
    rd(8'h30, 32'h20);
    chk(lc, 32'h3);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    @(posedge clk) run <= 1;
    s_defaults();
    waitp(0, 1, 10);
    s_undervolt();
    s_block();
    s_latched();
    s_option();
    s_nomotor();
    tally_and_finish();
  end
endmodule
